// [clpc_pkg.sv]
// clpc_pkg: register map, field positions, reset values and timing for clock lock/power control.
// assumes a 125 MHz system clock and a 16-bit plain register port.
package clpc_pkg;
	localparam int unsigned   DATA_W             = 16;
	localparam int unsigned   ADDR_W             = 16;

	// register offsets
	localparam logic [15:0]   ADDR_LOCK_STATUS   = 16'hf027;
	localparam logic [15:0]   ADDR_POWER_EN0     = 16'hf050;
	localparam logic [15:0]   ADDR_IRQ_STATUS    = 16'hf0e0;
	localparam logic [15:0]   ADDR_IRQ_MASK      = 16'hf0e1;

	// reset values
	localparam logic [15:0]   RST_LOCK_STATUS    = 16'h0000;
	localparam logic [15:0]   RST_POWER_EN0      = 16'h0000;
	localparam logic [1:0]    RST_IRQ            = 2'h0;
	localparam logic [15:0]   READ_ZERO          = 16'h0000;

	// field positions
	localparam int unsigned   LOCK_BIT           = 0;
	localparam int unsigned   PWR_GEN3_BIT       = 12;
	localparam int unsigned   PWR_GEN2_BIT       = 11;
	localparam logic [15:0]   PWR_RESERVED_MASK  = 16'he000;
	localparam int unsigned   IRQ_W              = 2;
	localparam int unsigned   IRQ_LOCK_GAIN_BIT  = 0;
	localparam int unsigned   IRQ_LOCK_LOSS_BIT  = 1;

	// reference selection for the precision generator
	localparam logic          REF_SEL_PLL        = 1'b0;
	localparam logic          REF_SEL_EXTERNAL   = 1'b1;

	// timing
	localparam int unsigned   CLK_PERIOD_NS      = 8;
	localparam int unsigned   LOCK_TIME_NS       = 2000;
	localparam int unsigned   REF_ACT_TIME_NS    = 20000;
	// least time: round up
	localparam int unsigned   LOCK_CYCLES        = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest time: round down
	localparam int unsigned   REF_ACT_CYCLES     = REF_ACT_TIME_NS / CLK_PERIOD_NS;

	// audio clock shape defaults
	localparam int unsigned   BCLK_HALF_CYCLES   = 4;
	localparam int unsigned   FRAME_HALF_BITS    = 32;
endpackage : clpc_pkg

// [clpc_lock_det.sv]
// clpc_lock_det: lock detector for the precision generator.
// assumes reference inputs are synchronous to the system clock.
`timescale 1ns/1ps
`default_nettype none
module clpc_lock_det
	import clpc_pkg::*;
#(
	parameter int unsigned LOCK_CNT = LOCK_CYCLES,
	parameter int unsigned ACT_CNT  = REF_ACT_CYCLES
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// control
	input  wire logic enable_in,
	input  wire logic ref_sel_in,
	// references
	input  wire logic pll_locked_in,
	input  wire logic ext_ref_in,
	// status
	output logic      locked_out
);
	localparam int unsigned LW = $clog2(LOCK_CNT + 1);
	localparam int unsigned AW = $clog2(ACT_CNT + 1);

	logic [LW-1:0] lock_cnt;
	logic [AW-1:0] act_cnt;
	logic          ext_prev;
	logic          ref_ok;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_prev <= 1'b0;
		end else begin
			ext_prev <= ext_ref_in;
		end
	end

	// external reference counts as present while edges keep coming
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			act_cnt <= '0;
		end else if (ext_ref_in != ext_prev) begin
			act_cnt <= AW'(ACT_CNT);
		end else if (act_cnt != '0) begin
			act_cnt <= act_cnt - AW'(1);
		end
	end

	assign ref_ok = (ref_sel_in == REF_SEL_EXTERNAL) ? (act_cnt != '0) : pll_locked_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lock_cnt   <= '0;
			locked_out <= 1'b0;
		end else if (!(enable_in && ref_ok)) begin
			lock_cnt   <= '0;
			locked_out <= 1'b0;
		end else if (lock_cnt == LW'(LOCK_CNT)) begin
			locked_out <= 1'b1;
		end else begin
			lock_cnt <= lock_cnt + LW'(1);
		end
	end
endmodule : clpc_lock_det
`default_nettype wire

// [clpc_clk_gen.sv]
// clpc_clk_gen: audio bit and frame clock generator with power enable.
// assumes outputs are sampled in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module clpc_clk_gen
	import clpc_pkg::*;
#(
	parameter int unsigned BCLK_HALF = BCLK_HALF_CYCLES,
	parameter int unsigned FRAME_HALF = FRAME_HALF_BITS
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// control
	input  wire logic enable_in,
	// audio clocks
	output logic      bclk_out,
	output logic      fclk_out
);
	localparam int unsigned DW = $clog2(BCLK_HALF + 1);
	localparam int unsigned FW = $clog2(FRAME_HALF + 1);

	logic [DW-1:0] div_cnt;
	logic [FW-1:0] bit_cnt;

	// disabled generator sits low and restarts cleanly
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_cnt  <= '0;
			bit_cnt  <= '0;
			bclk_out <= 1'b0;
			fclk_out <= 1'b0;
		end else if (!enable_in) begin
			div_cnt  <= '0;
			bit_cnt  <= '0;
			bclk_out <= 1'b0;
			fclk_out <= 1'b0;
		end else if (div_cnt == DW'(BCLK_HALF - 1)) begin
			div_cnt  <= '0;
			bclk_out <= !bclk_out;
			if (bclk_out) begin
				if (bit_cnt == FW'(FRAME_HALF - 1)) begin
					bit_cnt  <= '0;
					fclk_out <= !fclk_out;
				end else begin
					bit_cnt <= bit_cnt + FW'(1);
				end
			end
		end else begin
			div_cnt <= div_cnt + DW'(1);
		end
	end
endmodule : clpc_clk_gen
`default_nettype wire

// [clpc_ctrl.sv]
// clpc_ctrl: lock status for the precision generator and power enables for the second and precision generators.
// assumes a single-cycle register master and pins synchronous to SYS_CLK_IN.
`timescale 1ns/1ps
`default_nettype none
module clpc_ctrl
	import clpc_pkg::*;
#(
	parameter int unsigned PIN_COUNT  = 4,
	parameter int unsigned FUNC_COUNT = 4,
	parameter int unsigned LOCK_CNT   = LOCK_CYCLES,
	parameter int unsigned ACT_CNT    = REF_ACT_CYCLES,
	parameter int unsigned BCLK_HALF  = BCLK_HALF_CYCLES,
	parameter int unsigned FRAME_HALF = FRAME_HALF_BITS
) (
	// clock and reset
	input  wire logic                  SYS_CLK_IN,
	input  wire logic                  RESETN_IN,

	// register port
	input  wire logic [ADDR_W-1:0]     REG_ADDR_IN,
	input  wire logic [DATA_W-1:0]     REG_WDATA_IN,
	input  wire logic                  REG_WR_IN,
	input  wire logic                  REG_RD_IN,
	output logic      [DATA_W-1:0]     REG_RDATA_OUT,

	// interrupt
	output logic                       IRQ_OUT,

	// precision generator reference
	input  wire logic                  PRECISION_GEN_REF_SELECT_IN,
	input  wire logic                  PLL_LOCKED_IN,
	input  wire logic                  EXT_REF_IN,

	// clock pin routing
	input  wire logic [PIN_COUNT-1:0]  PIN_FROM_SECOND_GEN_IN,
	input  wire logic [PIN_COUNT-1:0]  ALT_FRAME_CLOCK_IN,
	input  wire logic [PIN_COUNT-1:0]  ALT_BIT_CLOCK_IN,
	output logic      [PIN_COUNT-1:0]  FRAME_CLOCK_OUT_PINS_OUT,
	output logic      [PIN_COUNT-1:0]  BIT_CLOCK_OUT_PINS_OUT,

	// generator clocks
	output logic                       SECOND_GEN_BCLK_OUT,
	output logic                       SECOND_GEN_FCLK_OUT,
	output logic                       PRECISION_GEN_BCLK_OUT,
	output logic                       PRECISION_GEN_FCLK_OUT,

	// function clock sources and run enables (core included)
	input  wire logic [FUNC_COUNT-1:0] FUNC_FROM_SECOND_GEN_IN,
	input  wire logic [FUNC_COUNT-1:0] FUNC_FROM_PRECISION_GEN_IN,
	output logic      [FUNC_COUNT-1:0] FUNC_RUN_OUT
);
	// power enable register and derived enables
	logic [DATA_W-1:0]  power_enable;
	logic               precision_gen_power_on;
	logic               second_gen_power_on;

	// lock state
	logic               precision_gen_locked;
	logic               locked_prev;
	logic               lock_gain;
	logic               lock_loss;

	// interrupt registers
	logic [IRQ_W-1:0]   irq_status;
	logic [IRQ_W-1:0]   irq_mask;
	logic [IRQ_W-1:0]   irq_events;
	logic [IRQ_W-1:0]   irq_clear;

	// register access decode
	logic               wr_power;
	logic               wr_irq_status;
	logic               wr_irq_mask;
	logic [DATA_W-1:0]  next_rdata;

	// generator clocks
	logic               gen2_bclk;
	logic               gen2_fclk;
	logic               gen3_bclk;
	logic               gen3_fclk;

	// pin and function next values
	logic [PIN_COUNT-1:0]  next_frame_pins;
	logic [PIN_COUNT-1:0]  next_bit_pins;
	logic [FUNC_COUNT-1:0] next_func_run;

	assign precision_gen_power_on = power_enable[PWR_GEN3_BIT];
	assign second_gen_power_on    = power_enable[PWR_GEN2_BIT];

	// write decode
	always_comb begin
		wr_power      = 1'b0;
		wr_irq_status = 1'b0;
		wr_irq_mask   = 1'b0;
		if (REG_WR_IN && (REG_ADDR_IN == ADDR_POWER_EN0)) begin
			wr_power = 1'b1;
		end else if (REG_WR_IN && (REG_ADDR_IN == ADDR_IRQ_STATUS)) begin
			wr_irq_status = 1'b1;
		end else if (REG_WR_IN && (REG_ADDR_IN == ADDR_IRQ_MASK)) begin
			wr_irq_mask = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			power_enable <= RST_POWER_EN0;
		end else if (wr_power) begin
			power_enable <= REG_WDATA_IN;
		end
	end

	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			irq_mask <= RST_IRQ;
		end else if (wr_irq_mask) begin
			irq_mask <= REG_WDATA_IN[IRQ_W-1:0];
		end
	end

	clpc_lock_det #(
		.LOCK_CNT   (LOCK_CNT),
		.ACT_CNT    (ACT_CNT)
	) u_lock_det (
		.clk_in        (SYS_CLK_IN),
		.rst_n_in      (RESETN_IN),
		.enable_in     (precision_gen_power_on),
		.ref_sel_in    (PRECISION_GEN_REF_SELECT_IN),
		.pll_locked_in (PLL_LOCKED_IN),
		.ext_ref_in    (EXT_REF_IN),
		.locked_out    (precision_gen_locked)
	);

	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			locked_prev <= 1'b0;
		end else begin
			locked_prev <= precision_gen_locked;
		end
	end

	assign lock_gain = precision_gen_locked && !locked_prev;
	assign lock_loss = !precision_gen_locked && locked_prev;

	always_comb begin
		irq_events                    = '0;
		irq_events[IRQ_LOCK_GAIN_BIT] = lock_gain;
		irq_events[IRQ_LOCK_LOSS_BIT] = lock_loss;
		irq_clear                     = wr_irq_status ? REG_WDATA_IN[IRQ_W-1:0] : '0;
	end

	// sticky events; a set in the clearing cycle survives
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			irq_status <= RST_IRQ;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	assign IRQ_OUT = |(irq_status & irq_mask);

	// read decode, unmapped reads zero
	always_comb begin
		next_rdata = READ_ZERO;
		if (REG_ADDR_IN == ADDR_LOCK_STATUS) begin
			next_rdata[LOCK_BIT] = precision_gen_locked;
		end else if (REG_ADDR_IN == ADDR_POWER_EN0) begin
			next_rdata = power_enable;
		end else if (REG_ADDR_IN == ADDR_IRQ_STATUS) begin
			next_rdata[IRQ_W-1:0] = irq_status;
		end else if (REG_ADDR_IN == ADDR_IRQ_MASK) begin
			next_rdata[IRQ_W-1:0] = irq_mask;
		end
	end

	// data stands only in the cycle after the strobe
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			REG_RDATA_OUT <= RST_LOCK_STATUS;
		end else if (REG_RD_IN) begin
			REG_RDATA_OUT <= next_rdata;
		end else begin
			REG_RDATA_OUT <= READ_ZERO;
		end
	end

	clpc_clk_gen #(
		.BCLK_HALF  (BCLK_HALF),
		.FRAME_HALF (FRAME_HALF)
	) u_gen2 (
		.clk_in    (SYS_CLK_IN),
		.rst_n_in  (RESETN_IN),
		.enable_in (second_gen_power_on),
		.bclk_out  (gen2_bclk),
		.fclk_out  (gen2_fclk)
	);

	clpc_clk_gen #(
		.BCLK_HALF  (BCLK_HALF),
		.FRAME_HALF (FRAME_HALF)
	) u_gen3 (
		.clk_in    (SYS_CLK_IN),
		.rst_n_in  (RESETN_IN),
		.enable_in (precision_gen_power_on),
		.bclk_out  (gen3_bclk),
		.fclk_out  (gen3_fclk)
	);

	assign SECOND_GEN_BCLK_OUT    = gen2_bclk;
	assign SECOND_GEN_FCLK_OUT    = gen2_fclk;
	assign PRECISION_GEN_BCLK_OUT = gen3_bclk;
	assign PRECISION_GEN_FCLK_OUT = gen3_fclk;

	// pin routing, one lane per pin
	genvar gp;
	generate
		for (gp = 0; gp < PIN_COUNT; gp++) begin : g_pin
			always_comb begin
				if (PIN_FROM_SECOND_GEN_IN[gp]) begin
					next_frame_pins[gp] = second_gen_power_on && gen2_fclk;
					next_bit_pins[gp]   = second_gen_power_on && gen2_bclk;
				end else begin
					next_frame_pins[gp] = ALT_FRAME_CLOCK_IN[gp];
					next_bit_pins[gp]   = ALT_BIT_CLOCK_IN[gp];
				end
			end
		end
	endgenerate

	// registered pins add one cycle but avoid glitches on the pads
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			FRAME_CLOCK_OUT_PINS_OUT <= '0;
			BIT_CLOCK_OUT_PINS_OUT   <= '0;
		end else begin
			FRAME_CLOCK_OUT_PINS_OUT <= next_frame_pins;
			BIT_CLOCK_OUT_PINS_OUT   <= next_bit_pins;
		end
	end

	// function run enables, one lane per function
	genvar gf;
	generate
		for (gf = 0; gf < FUNC_COUNT; gf++) begin : g_func
			always_comb begin
				next_func_run[gf] = 1'b1;
				if (FUNC_FROM_SECOND_GEN_IN[gf] && !second_gen_power_on) begin
					next_func_run[gf] = 1'b0;
				end
				if (FUNC_FROM_PRECISION_GEN_IN[gf] && !precision_gen_power_on) begin
					next_func_run[gf] = 1'b0;
				end
			end
		end
	endgenerate

	// everything halted at reset since no generator is on yet
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			FUNC_RUN_OUT <= '0;
		end else begin
			FUNC_RUN_OUT <= next_func_run;
		end
	end
endmodule : clpc_ctrl
`default_nettype wire

// [clpc_ctrl_props.sv]
// clpc_ctrl_props: port checker for lock status, power enables and pins.
// assumes bind into clpc_ctrl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module clpc_ctrl_props
	import clpc_pkg::*;
#(
	parameter int unsigned PIN_COUNT  = 4,
	parameter int unsigned FUNC_COUNT = 4
) (
	input wire logic                  SYS_CLK_IN,
	input wire logic                  RESETN_IN,
	input wire logic [ADDR_W-1:0]     REG_ADDR_IN,
	input wire logic [DATA_W-1:0]     REG_WDATA_IN,
	input wire logic                  REG_WR_IN,
	input wire logic                  REG_RD_IN,
	input wire logic [DATA_W-1:0]     REG_RDATA_OUT,
	input wire logic [PIN_COUNT-1:0]  PIN_FROM_SECOND_GEN_IN,
	input wire logic [PIN_COUNT-1:0]  ALT_BIT_CLOCK_IN,
	input wire logic [PIN_COUNT-1:0]  FRAME_CLOCK_OUT_PINS_OUT,
	input wire logic [PIN_COUNT-1:0]  BIT_CLOCK_OUT_PINS_OUT,
	input wire logic                  SECOND_GEN_BCLK_OUT,
	input wire logic                  SECOND_GEN_FCLK_OUT,
	input wire logic                  PRECISION_GEN_BCLK_OUT,
	input wire logic                  PRECISION_GEN_FCLK_OUT,
	input wire logic [FUNC_COUNT-1:0] FUNC_FROM_SECOND_GEN_IN,
	input wire logic [FUNC_COUNT-1:0] FUNC_FROM_PRECISION_GEN_IN,
	input wire logic [FUNC_COUNT-1:0] FUNC_RUN_OUT
);
	// shadow of the power register, same timing as the real one
	logic [15:0] pwr;
	always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			pwr <= RST_POWER_EN0;
		end else if (REG_WR_IN && REG_ADDR_IN == ADDR_POWER_EN0) begin
			pwr <= REG_WDATA_IN;
		end
	end
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	lock_resv_a: assert property (
		$past(REG_RD_IN && REG_ADDR_IN == ADDR_LOCK_STATUS) |-> REG_RDATA_OUT[15:1] == 15'h0000)
		else $error("lock status reserved bits not zero");
	pwr_read_a: assert property (
		$past(REG_RD_IN && REG_ADDR_IN == ADDR_POWER_EN0) |-> REG_RDATA_OUT == pwr)
		else $error("power enable read mismatch");
	gen2_off_a: assert property (
		!pwr[11] && !$past(pwr[11]) |-> !SECOND_GEN_BCLK_OUT && !SECOND_GEN_FCLK_OUT)
		else $error("second generator runs while off");
	gen3_off_a: assert property (
		!pwr[12] && !$past(pwr[12]) |-> !PRECISION_GEN_BCLK_OUT && !PRECISION_GEN_FCLK_OUT)
		else $error("precision generator runs while off");
	pins_low_a: assert property (
		!pwr[11] && !$past(pwr[11]) && !$past(pwr[11], 2) |->
		((FRAME_CLOCK_OUT_PINS_OUT | BIT_CLOCK_OUT_PINS_OUT) & $past(PIN_FROM_SECOND_GEN_IN)) == '0)
		else $error("second generator pin not low");
	pin_pass_a: assert property (
		$past(RESETN_IN) |-> (BIT_CLOCK_OUT_PINS_OUT & ~$past(PIN_FROM_SECOND_GEN_IN))
		== ($past(ALT_BIT_CLOCK_IN) & ~$past(PIN_FROM_SECOND_GEN_IN)))
		else $error("other pin disturbed");
	func_halt_a: assert property (
		((FUNC_RUN_OUT & $past(FUNC_FROM_SECOND_GEN_IN) & {FUNC_COUNT{!$past(pwr[11])}})
		| (FUNC_RUN_OUT & $past(FUNC_FROM_PRECISION_GEN_IN) & {FUNC_COUNT{!$past(pwr[12])}})) == '0)
		else $error("function runs on disabled generator");
	lock_off_a: assert property (
		$past(REG_RD_IN && REG_ADDR_IN == ADDR_LOCK_STATUS) && !$past(pwr[12], 2)
		&& !$past(pwr[12], 3) && !$past(pwr[12], 4) |-> !REG_RDATA_OUT[0])
		else $error("lock reported while generator off");
endmodule : clpc_ctrl_props
bind clpc_ctrl clpc_ctrl_props #(.PIN_COUNT(PIN_COUNT), .FUNC_COUNT(FUNC_COUNT)) u_props (
	.SYS_CLK_IN(SYS_CLK_IN), .RESETN_IN(RESETN_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .PIN_FROM_SECOND_GEN_IN(PIN_FROM_SECOND_GEN_IN),
	.ALT_BIT_CLOCK_IN(ALT_BIT_CLOCK_IN), .FRAME_CLOCK_OUT_PINS_OUT(FRAME_CLOCK_OUT_PINS_OUT),
	.BIT_CLOCK_OUT_PINS_OUT(BIT_CLOCK_OUT_PINS_OUT), .SECOND_GEN_BCLK_OUT(SECOND_GEN_BCLK_OUT),
	.SECOND_GEN_FCLK_OUT(SECOND_GEN_FCLK_OUT), .PRECISION_GEN_BCLK_OUT(PRECISION_GEN_BCLK_OUT),
	.PRECISION_GEN_FCLK_OUT(PRECISION_GEN_FCLK_OUT),
	.FUNC_FROM_SECOND_GEN_IN(FUNC_FROM_SECOND_GEN_IN),
	.FUNC_FROM_PRECISION_GEN_IN(FUNC_FROM_PRECISION_GEN_IN), .FUNC_RUN_OUT(FUNC_RUN_OUT));
`default_nettype wire

// [clpc_ctrl_tb_top.sv]
// clpc_ctrl_tb_top: self-checking bench for lock status and power enables.
// assumes clpc_pkg, the design and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module clpc_ctrl_tb_top
	import clpc_pkg::*;
;
	logic        clk, rst_n, reg_wr, reg_rd, ref_sel, pll_lk, ext_ref, ext_run, irq, rd_q;
	logic [15:0] addr, wdata, rdata, v;
	logic [3:0]  pin_sel, alt_f, alt_b, f_pins, b_pins, f2, f3, run;
	logic        g2b, g2f, g3b, g3f;
	logic [15:0] expq[$];
	int          n_errors, n_tests, cyc, cb, cf;
	// short counts keep the run brief
	clpc_ctrl #(.LOCK_CNT(4), .ACT_CNT(16), .BCLK_HALF(2), .FRAME_HALF(2)) u_dut (
		.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata), .IRQ_OUT(irq),
		.PRECISION_GEN_REF_SELECT_IN(ref_sel), .PLL_LOCKED_IN(pll_lk), .EXT_REF_IN(ext_ref),
		.PIN_FROM_SECOND_GEN_IN(pin_sel), .ALT_FRAME_CLOCK_IN(alt_f), .ALT_BIT_CLOCK_IN(alt_b),
		.FRAME_CLOCK_OUT_PINS_OUT(f_pins), .BIT_CLOCK_OUT_PINS_OUT(b_pins),
		.SECOND_GEN_BCLK_OUT(g2b), .SECOND_GEN_FCLK_OUT(g2f), .PRECISION_GEN_BCLK_OUT(g3b),
		.PRECISION_GEN_FCLK_OUT(g3f), .FUNC_FROM_SECOND_GEN_IN(f2),
		.FUNC_FROM_PRECISION_GEN_IN(f3), .FUNC_RUN_OUT(run));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic complete_run;
		$display("tests %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask : ticks
	task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
		expq.push_back(e);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : rd_reg
	// write then read with no gap
	task automatic wr_rd(input logic [15:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		expq.push_back(d);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask : wr_rd
	// read data stands one cycle only, so look mid-cycle
	always @(posedge clk) rd_q <= reg_rd;
	always @(negedge clk) if (rd_q) chk("rdata", expq.pop_front(), rdata);
	always @(posedge clk) if (ext_run) ext_ref <= ~ext_ref;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		{rst_n, reg_wr, reg_rd, ref_sel, pll_lk, ext_ref, ext_run} = 7'h00;
		{addr, wdata, alt_f, alt_b} = 40'h0;
		pin_sel = 4'h5;
		f2 = 4'h3;
		f3 = 4'h4;
		void'($urandom(12));
		ticks(5);
		rst_n <= 1'b1;
		ticks(1);
		alt_f <= 4'($urandom);
		alt_b <= 4'($urandom);
		rd_reg(ADDR_LOCK_STATUS, RST_LOCK_STATUS);
		rd_reg(ADDR_POWER_EN0, RST_POWER_EN0);
		rd_reg(16'h1000 | 16'($urandom) & 16'h0fff, READ_ZERO);
		chk("alt", {8'h0, alt_f & 4'ha, alt_b & 4'ha}, {8'h0, f_pins & 4'ha, b_pins & 4'ha});
		chk("run", 16'h0008, {12'h0, run});
		v = 16'($urandom) & 16'he7ff | PWR_RESERVED_MASK;
		wr_rd(ADDR_POWER_EN0, v);
		ticks(30);
		chk("gens", 16'h0000, {12'h0, g2b, g2f, g3b, g3f});
		wr_reg(ADDR_POWER_EN0, 16'h0800);
		cb = 0;
		cf = 0;
		repeat (40) begin
			@(posedge clk);
			cb += b_pins[0];
			cf += f_pins[0];
		end
		chk("bclk", 16'h0001, {15'h0, cb > 5 && cb < 35});
		chk("fclk", 16'h0001, {15'h0, cf > 5 && cf < 35});
		chk("run", 16'h000b, {12'h0, run});
		wr_reg(ADDR_POWER_EN0, 16'h0000);
		ticks(3);
		cb = 0;
		repeat (20) begin
			@(posedge clk);
			cb += b_pins[0] | f_pins[0] | g2b | g2f;
		end
		chk("off", 16'h0000, 16'(cb));
		chk("run", 16'h0008, {12'h0, run});
		wr_reg(ADDR_IRQ_MASK, 16'h0003);
		pll_lk <= 1'b1;
		wr_reg(ADDR_POWER_EN0, 16'h1000);
		cb = 0;
		repeat (12) begin
			@(posedge clk);
			cb += g3b;
		end
		chk("g3clk", 16'h0001, {15'h0, cb > 2 && cb < 10});
		rd_reg(ADDR_LOCK_STATUS, 16'h0001);
		chk("irq", 16'h0001, {15'h0, irq});
		chk("run", 16'h000c, {12'h0, run});
		rd_reg(ADDR_IRQ_STATUS, 16'h0001);
		wr_reg(ADDR_IRQ_MASK, 16'h0002);
		chk("irq", 16'h0000, {15'h0, irq});
		wr_reg(ADDR_IRQ_STATUS, 16'h0001);
		chk("irq", 16'h0000, {15'h0, irq});
		wr_reg(ADDR_POWER_EN0, 16'h0000);
		ticks(3);
		rd_reg(ADDR_LOCK_STATUS, 16'h0000);
		chk("run", 16'h0008, {12'h0, run});
		rd_reg(ADDR_IRQ_STATUS, 16'h0002);
		chk("irq", 16'h0001, {15'h0, irq});
		wr_reg(ADDR_IRQ_STATUS, 16'h0003);
		ref_sel <= 1'b1;
		pll_lk <= 1'b0;
		ext_run <= 1'b1;
		wr_reg(ADDR_POWER_EN0, 16'h1000);
		ticks(12);
		rd_reg(ADDR_LOCK_STATUS, 16'h0001);
		ext_run <= 1'b0;
		ticks(30);
		rd_reg(ADDR_LOCK_STATUS, 16'h0000);
		ticks(2);
		complete_run();
	end
endmodule : clpc_ctrl_tb_top
`default_nettype wire
